// ---- verilog/mutual_cap_scan_defs.vh ----
// constants for the mutual-capacitance scan controller
// assumes it is included by bare name from the design file
`ifndef MUTUAL_CAP_SCAN_DEFS_VH
`define MUTUAL_CAP_SCAN_DEFS_VH
// clock source selections
`define SRC_DIRECT        2'h0
`define SRC_SPREAD        2'h1
`define SRC_PSEUDO_RANDOM 2'h2
`define SRC_AUTO          2'h3
// dac limits
`define REF_MIN_UNCOMP    8'h06
`define REF_COMP_NUM      8'h0A
`define COMP_MIN_AT_REF1  8'h62
`define COMP_DIV_MIN      8'h04
// calibration target in percent of max count
`define CAL_TARGET_PCT    8'h28
// spread spectrum base offset, cycles always added above the divider
`define SPREAD_SWING      4'h3
// phase lengths in modulator clocks
`define PRECHARGE_CYCLES  16'h0010
`define SHORT_CYCLES      16'h0010
`endif

// ---- verilog/mutual_cap_scan_control.v ----
// mutual-capacitance scan sequencer: init phases, tx clock, dac switching,
// raw count and auto-calibration of the reference dac code
// assumes one 25 MHz clock; start_in comes from logic on that clock
// compare_in is a raw comparator level and is synchronised here
`timescale 1ns/1ps
`include "mutual_cap_scan_defs.vh"
module mutual_cap_scan_control #(
  parameter CW = 16   // counter width
) (
  input  wire          clk_in,
  input  wire          resetn_in,
  input  wire          start_in,                 // one-cycle scan request
  input  wire [1:0]    clock_source_in,          // tx clock source selection
  input  wire          widget_spread_in,         // auto choice for this widget
  input  wire [7:0]    tx_clock_divider_in,      // modulator clocks per tx period
  input  wire [7:0]    comp_divider_in,          // compensation divider
  input  wire [CW-1:0] subconversion_count_in,   // measured sub-conversions
  input  wire [7:0]    init_subconversions_in,   // discarded sub-conversions
  input  wire          comp_enable_in,           // dual dac mode
  input  wire          autocal_enable_in,        // auto-calibration
  input  wire [7:0]    reference_dac_code_in,    // fixed code, no calibration
  input  wire [7:0]    compensation_dac_code_in, // requested compensation code
  input  wire          compare_in,               // modulator comparator, from pin
  output reg           cap1_to_ground_out,
  output reg           cap2_to_supply_out,
  output reg           caps_shorted_out,
  output reg           tx_clock_out,
  output reg           ref_dac_switch_out,       // one-cycle switching event
  output reg           comp_dac_switch_out,      // one-cycle switching event
  output reg  [7:0]    ref_code_out,             // code in use (lsb = 8.86 fF)
  output reg  [7:0]    comp_code_out,
  output reg  [CW-1:0] raw_count_out,
  output reg           scan_done_out,
  output reg           busy_out,
  output reg           config_error_out
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam S_IDLE   = 3'h0;
  localparam S_PRECHG = 3'h1;
  localparam S_SHORT  = 3'h2;
  localparam S_INIT   = 3'h3;
  localparam S_MEAS   = 3'h4;
  localparam S_DONE   = 3'h5;
  // codes six and seven are unused and fall back to idle

  // sequencer storage; all of it is set by reset, tx_len, lfsr and cal_code to non-zero values
  // the phase counter is shared by precharge and short, only one runs at a time
  reg  [2:0]    state;        // sequencer state
  reg  [15:0]   phase_cnt;    // cycles in precharge/short
  reg  [7:0]    tx_cnt;       // position in tx period
  reg  [7:0]    tx_len;       // current period length
  reg  [CW-1:0] sub_cnt;      // sub-conversions done in phase
  reg  [CW-1:0] hits;         // ref switching events counted
  reg  [3:0]    lfsr;         // spread and pseudo-random sequence
  reg  [7:0]    comp_cnt;     // compensation sub-divider
  reg  [7:0]    cal_code;     // calibrated reference code
  reg           cmp_meta;     // synchroniser first stage
  reg           cmp_sync;     // synchroniser second stage

  // combinational helpers derived from the live configuration
  wire          use_spread;
  wire [7:0]    base_len;
  wire [7:0]    spread_len;
  wire          period_end;
  wire [CW-1:0] max_count;
  wire [CW-1:0] raw_now;
  wire [CW+7:0] target;

  // ****************************************************************
  // comparator synchroniser
  // ****************************************************************
  // the first stage feeds only the second, keeping metastability out
  // two flops cost two cycles of latency on every comparator hit
  // reset value matches the comparator's quiet level
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= compare_in;
      cmp_sync <= cmp_meta;
    end
  end

  // ****************************************************************
  // tx clock source
  // ****************************************************************
  // pseudo-random shares the spread path: both only need a period that wanders
  // the auto choice is made outside, per widget, and arrives as widget_spread_in
  // selections are levels; a change mid-scan takes effect at the next period
  // auto source choice
  assign use_spread = (clock_source_in == `SRC_SPREAD) ||
                      (clock_source_in == `SRC_PSEUDO_RANDOM) ||
                      ((clock_source_in == `SRC_AUTO) && widget_spread_in);
  // divider below two would stop the tx clock, so clamp it
  assign base_len   = (tx_clock_divider_in < 8'h02) ? 8'h02 : tx_clock_divider_in;
  // period wanders within a fixed swing
  assign spread_len = base_len + {5'h00, lfsr[2:0] & 3'h3} + {4'h0, `SPREAD_SWING};
  // period end compares against the length latched for this period
  assign period_end = (tx_cnt == tx_len - 8'h01);

  // max count uses the nominal divider even when the period wanders, so a
  // spread scan still reports against the same full scale
  // the product is kept to CW bits; subs times divider must fit in range
  // one sub-conversion per tx period
  // max count = subs times divider
  assign max_count = subconversion_count_in * {{(CW-8){1'b0}}, tx_clock_divider_in};
  assign raw_now   = max_count - hits;
  // the target is a whole-count floor; the remainder is dropped
  // a sized hundred keeps the division at the target's own width
  // forty percent of max count
  assign target    = ({8'h00, max_count} * {{CW{1'b0}}, `CAL_TARGET_PCT}) / {{CW{1'b0}}, 8'h64};

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one process runs the whole scan so phase outputs never overlap
  // every output is a flop, so the analog switches see no decode glitches
  // reset clears all outputs; the calibrated code restarts at mid scale
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state               <= S_IDLE;
      phase_cnt           <= 16'h0000;
      tx_cnt              <= 8'h00;
      tx_len              <= 8'h02;
      sub_cnt             <= {CW{1'b0}};
      hits                <= {CW{1'b0}};
      lfsr                <= 4'h1;
      comp_cnt            <= 8'h00;
      cal_code            <= 8'h80;
      cap1_to_ground_out  <= 1'b0;
      cap2_to_supply_out  <= 1'b0;
      caps_shorted_out    <= 1'b0;
      tx_clock_out        <= 1'b0;
      ref_dac_switch_out  <= 1'b0;
      comp_dac_switch_out <= 1'b0;
      ref_code_out        <= 8'h00;
      comp_code_out       <= 8'h00;
      raw_count_out       <= {CW{1'b0}};
      scan_done_out       <= 1'b0;
      busy_out            <= 1'b0;
      config_error_out    <= 1'b0;
    end else begin
      // events default to idle each cycle
      // switch pulses last one cycle so the front end counts each edge once
      scan_done_out       <= 1'b0;
      ref_dac_switch_out  <= 1'b0;
      comp_dac_switch_out <= 1'b0;
      // with compensation off the code shown is zero, matching the idle dac
      // codes shown follow calibration and comp enable
      ref_code_out  <= autocal_enable_in ? cal_code : reference_dac_code_in;
      comp_code_out <= comp_enable_in ? compensation_dac_code_in : 8'h00;
      // limits the firmware must keep; flagged, not enforced
      // reference minimum
      // comp divider floor and whole switch count
      config_error_out <= (!comp_enable_in && ref_code_out < `REF_MIN_UNCOMP) ||
                          (comp_enable_in && ({8'h00, ref_code_out} * {8'h00, comp_divider_in}
                                              < {8'h00, `REF_COMP_NUM})) ||
                          (comp_enable_in && ref_code_out == 8'h01 &&
                           compensation_dac_code_in < `COMP_MIN_AT_REF1) ||
                          (comp_enable_in && comp_divider_in < `COMP_DIV_MIN) ||
                          (comp_enable_in && comp_divider_in != 8'h00 &&
                           (tx_clock_divider_in % comp_divider_in) != 8'h00);
      case (state)
        S_IDLE: begin
          // a start outside idle is ignored without any indication
          // busy drops here, one cycle after the done pulse
          busy_out     <= 1'b0;
          tx_clock_out <= 1'b0;
          if (start_in) begin
            state              <= S_PRECHG;
            busy_out           <= 1'b1;
            phase_cnt          <= 16'h0000;
            // cap one ground, cap two supply
            cap1_to_ground_out <= 1'b1;
            cap2_to_supply_out <= 1'b1;
          end
        end
        S_PRECHG: begin
          // a fixed count; the caps need no feedback to settle
          phase_cnt <= phase_cnt + 16'h0001;
          if (phase_cnt == `PRECHARGE_CYCLES - 16'h0001) begin
            cap1_to_ground_out <= 1'b0;
            cap2_to_supply_out <= 1'b0;
            caps_shorted_out   <= 1'b1;
            phase_cnt          <= 16'h0000;
            state              <= S_SHORT;
          end
        end
        S_SHORT: begin
          // the tx counter and per-scan counts restart here, so a cut scan
          // leaves nothing behind for the next one
          phase_cnt <= phase_cnt + 16'h0001;
          if (phase_cnt == `SHORT_CYCLES - 16'h0001) begin
            caps_shorted_out <= 1'b0;
            tx_cnt           <= 8'h00;
            sub_cnt          <= {CW{1'b0}};
            hits             <= {CW{1'b0}};
            comp_cnt         <= 8'h00;
            tx_len           <= use_spread ? spread_len : base_len;
            state            <= (init_subconversions_in == 8'h00) ? S_MEAS : S_INIT;
          end
        end
        S_INIT, S_MEAS: begin
          // tx high for the first half of each period, low for the rest
          tx_cnt       <= period_end ? 8'h00 : tx_cnt + 8'h01;
          tx_clock_out <= (tx_cnt < {1'b0, tx_len[7:1]});
          // hits during init subs drive the ref dac but are not counted
          // a hit in the last cycle of init is still dropped
          // ref switch when comparator trips
          if (cmp_sync) begin
            ref_dac_switch_out <= 1'b1;
            if (state == S_MEAS)
              hits <= hits + {{(CW-1){1'b0}}, 1'b1};
          end
          // the counter restarts each period, so a divider that does not divide
          // the tx divider cuts the last interval short; config_error_out flags it
          // comp switches every comp divider cycles
          // only with a non-zero requested code
          if (comp_enable_in && compensation_dac_code_in != 8'h00) begin
            if (comp_cnt >= comp_divider_in - 8'h01) begin
              comp_cnt            <= 8'h00;
              comp_dac_switch_out <= 1'b1;
            end else begin
              comp_cnt <= comp_cnt + 8'h01;
            end
          end
          // the sequence steps even in direct mode, so a later switch to
          // spread does not always start from the same length
          if (period_end) begin
            comp_cnt <= 8'h00;
            lfsr     <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            tx_len   <= use_spread ? spread_len : base_len;
            sub_cnt  <= sub_cnt + {{(CW-1){1'b0}}, 1'b1};
            // init counts dropped at phase end
            if (state == S_INIT &&
                sub_cnt == {{(CW-8){1'b0}}, init_subconversions_in} - {{(CW-1){1'b0}}, 1'b1}) begin
              sub_cnt <= {CW{1'b0}};
              hits    <= {CW{1'b0}};
              state   <= S_MEAS;
            end
            // the done state costs one extra cycle after the last period
            // finish after measured count
            if (state == S_MEAS && sub_cnt == subconversion_count_in - {{(CW-1){1'b0}}, 1'b1})
              state <= S_DONE;
          end
        end
        S_DONE: begin
          // tx is parked low so the sensor sees no stray edge between scans
          tx_clock_out  <= 1'b0;
          raw_count_out <= raw_now;
          scan_done_out <= 1'b1;
          // the raw count is latched once per scan and held until the next done
          // calibration moves one step per scan, so it settles over several scans
          // the code never reaches zero: a zero reference would stop the balance
          // step code toward target
          // code drives capacitance one lsb per step
          if (autocal_enable_in) begin
            if ({8'h00, raw_now} < target && cal_code != 8'hFF)
              cal_code <= cal_code + 8'h01;
            else if ({8'h00, raw_now} > target && cal_code != 8'h01)
              cal_code <= cal_code - 8'h01;
          end
          state <= S_IDLE;
        end
        // unused codes fall back to idle
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ---- bench/mutual_cap_scan_asserts.sv ----
// checker for the scan sequencer, bound onto the ports of its top module
// assumes the constants header and one clock domain
`timescale 1ns/1ps
`include "mutual_cap_scan_defs.vh"
module mutual_cap_scan_asserts #(parameter CW = 16) (
  input wire          clk_in,
  input wire          resetn_in,
  input wire          start_in,
  input wire [1:0]    clock_source_in,
  input wire          widget_spread_in,
  input wire [7:0]    tx_clock_divider_in,
  input wire          comp_enable_in,
  input wire          cap1_to_ground_out,
  input wire          cap2_to_supply_out,
  input wire          caps_shorted_out,
  input wire          tx_clock_out,
  input wire          ref_dac_switch_out,
  input wire          comp_dac_switch_out,
  input wire [CW-1:0] raw_count_out,
  input wire          scan_done_out,
  input wire          busy_out
);
  // ****
  // tx period tracking
  // ****
  reg  [7:0] gap;   // cycles since the last tx rise, wraps harmlessly when idle
  reg        tx_q;  // tx level one cycle back
  reg        seen;  // a rise already seen in this scan, so gap is a full period
  wire       rise = tx_clock_out & ~tx_q;
  wire       fixed = (clock_source_in == `SRC_DIRECT) | ((clock_source_in == `SRC_AUTO) & ~widget_spread_in);
  // period counter restarts on every rise
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap  <= 8'h00;
      tx_q <= 1'h0;
      seen <= 1'h0;
    end else begin
      tx_q <= tx_clock_out;
      gap  <= rise ? 8'h01 : gap + 8'h01;
      seen <= busy_out & (seen | rise);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ****
  // properties
  // ****
  property p_start; start_in && !busy_out |=> busy_out && cap1_to_ground_out && cap2_to_supply_out; endproperty
  a_start: assert property (p_start) else $error("scan did not open with precharge");
  property p_pre_len; $rose(cap1_to_ground_out) |-> ##15 cap1_to_ground_out ##1 (!cap1_to_ground_out && caps_shorted_out); endproperty
  a_pre_len: assert property (p_pre_len) else $error("precharge length or short order wrong");
  property p_pre_pair; cap1_to_ground_out |-> cap2_to_supply_out && !caps_shorted_out; endproperty
  a_pre_pair: assert property (p_pre_pair) else $error("precharge switch pair wrong");
  property p_short_len; $rose(caps_shorted_out) |-> ##15 caps_shorted_out ##1 !caps_shorted_out; endproperty
  a_short_len: assert property (p_short_len) else $error("short phase length wrong");
  property p_quiet; cap1_to_ground_out || caps_shorted_out |-> !tx_clock_out && !ref_dac_switch_out && !comp_dac_switch_out; endproperty
  a_quiet: assert property (p_quiet) else $error("switching during cap init");
  property p_period; rise && seen && fixed |-> gap == tx_clock_divider_in; endproperty
  a_period: assert property (p_period) else $error("direct tx period not fixed");
  property p_comp_off; !comp_enable_in |-> !comp_dac_switch_out; endproperty
  a_comp_off: assert property (p_comp_off) else $error("comp dac switched while disabled");
  property p_raw_hold; !scan_done_out |-> $stable(raw_count_out); endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw count moved without done");
  property p_done; scan_done_out |=> !scan_done_out; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule
bind mutual_cap_scan_control mutual_cap_scan_asserts #(.CW(CW)) i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .start_in(start_in), .clock_source_in(clock_source_in), .widget_spread_in(widget_spread_in),
  .tx_clock_divider_in(tx_clock_divider_in), .comp_enable_in(comp_enable_in), .cap1_to_ground_out(cap1_to_ground_out),
  .cap2_to_supply_out(cap2_to_supply_out), .caps_shorted_out(caps_shorted_out), .tx_clock_out(tx_clock_out),
  .ref_dac_switch_out(ref_dac_switch_out), .comp_dac_switch_out(comp_dac_switch_out),
  .raw_count_out(raw_count_out), .scan_done_out(scan_done_out), .busy_out(busy_out));

// ---- bench/analog_front_model.sv ----
// comparator model of the analog front end
// assumes the end of the short phase starts the sub-conversions
`timescale 1ns/1ps
module analog_front_model (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        shorted_in,    // sequencer short phase
  input  wire [15:0] init_trips_in, // cycles of trips after the short phase
  input  wire        flood_in,      // trip through the measured part too
  output reg         compare_out
);
  reg        arm;   // short phase has ended in this scan
  reg        sh_q;  // short phase one cycle back
  reg [15:0] since; // cycles since the short phase ended
  // trips kept inside the discarded subs unless flooding
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arm         <= 1'h0;
      sh_q        <= 1'h0;
      since       <= 16'h0000;
      compare_out <= 1'h0;
    end else begin
      sh_q        <= shorted_in;
      arm         <= ~shorted_in & (arm | sh_q);
      since       <= (sh_q & ~shorted_in) ? 16'h0000 : since + 16'h0001;
      compare_out <= arm & ((since < init_trips_in) | flood_in);
    end
  end
endmodule

// ---- bench/mutual_cap_scan_control_tb.sv ----
// self-checking bench for the scan sequencer: table of scans, then awkward cases
// assumes the design, its header, the front-end model and the checker
`timescale 1ns/1ps
`include "mutual_cap_scan_defs.vh"
module mutual_cap_scan_control_tb;
  typedef struct {logic [1:0] src; logic ws, ce, err; logic [7:0] div, cd, rf, cc, ini; logic [15:0] n;} row_t;
  reg         clk_in, resetn_in, start_in, widget_spread_in, comp_enable_in, autocal_enable_in, flood;
  reg  [1:0]  clock_source_in;
  reg  [7:0]  tx_clock_divider_in, comp_divider_in, init_subconversions_in;
  reg  [7:0]  reference_dac_code_in, compensation_dac_code_in;
  reg  [15:0] subconversion_count_in;
  wire        cap1_to_ground_out, cap2_to_supply_out, caps_shorted_out, tx_clock_out, ref_dac_switch_out;
  wire        comp_dac_switch_out, scan_done_out, busy_out, config_error_out, compare_in;
  wire [7:0]  ref_code_out, comp_code_out;
  wire [15:0] raw_count_out;
  int         error_cnt = 0;
  int         check_count = 0;
  // firmware limits broken on purpose in rows flagged err
  // fixed reference codes are low, 5, 6 or 10, outside the rows at the limits
  // the pseudo-random row runs without calibration, so no target applies
  row_t rows[7] = '{
    '{`SRC_DIRECT, 1'h0, 1'h1, 1'h0, 8'h08, 8'h04, 8'h06, 8'h14, 8'h02, 16'h0004},
    '{`SRC_DIRECT, 1'h0, 1'h0, 1'h1, 8'h08, 8'h04, 8'h05, 8'h00, 8'h02, 16'h0004},
    '{`SRC_SPREAD, 1'h0, 1'h1, 1'h0, 8'h08, 8'h04, 8'h0A, 8'h14, 8'h02, 16'h0004},
    '{`SRC_PSEUDO_RANDOM, 1'h0, 1'h1, 1'h1, 8'h08, 8'h03, 8'h0A, 8'h14, 8'h02, 16'h0004},
    '{`SRC_AUTO, 1'h0, 1'h1, 1'h1, 8'h0C, 8'h0C, 8'h01, 8'h61, 8'h03, 16'h0003},
    '{`SRC_AUTO, 1'h1, 1'h1, 1'h0, 8'h0C, 8'h0C, 8'h01, 8'h62, 8'h03, 16'h0003},
    '{`SRC_DIRECT, 1'h0, 1'h1, 1'h1, 8'h0A, 8'h04, 8'h0A, 8'h14, 8'h02, 16'h0005}};
  mutual_cap_scan_control i_dut (.clk_in, .resetn_in, .start_in, .clock_source_in, .widget_spread_in,
    .tx_clock_divider_in, .comp_divider_in, .subconversion_count_in, .init_subconversions_in, .comp_enable_in,
    .autocal_enable_in, .reference_dac_code_in, .compensation_dac_code_in, .compare_in, .cap1_to_ground_out,
    .cap2_to_supply_out, .caps_shorted_out, .tx_clock_out, .ref_dac_switch_out, .comp_dac_switch_out,
    .ref_code_out, .comp_code_out, .raw_count_out, .scan_done_out, .busy_out, .config_error_out);
  // trips end a few cycles early so the two-flop sync cannot spill into measured subs
  analog_front_model i_front (.clk_in(clk_in), .resetn_in(resetn_in), .shorted_in(caps_shorted_out),
    .init_trips_in(16'(init_subconversions_in * tx_clock_divider_in) - 16'h0006), .flood_in(flood),
    .compare_out(compare_in));
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one scan; poke repeats start mid-scan, which must be ignored
  task automatic do_row(input row_t r, input logic poke);
    int   cyc, rises, comps, refs, gap, first, span;
    logic ptx, fixed;
    fixed = r.src == `SRC_DIRECT || (r.src == `SRC_AUTO && !r.ws);
    span = (r.ini + r.n) * r.div;
    {cyc, rises, comps, refs, gap, first, ptx} = 0;
    @(posedge clk_in);
    #2;
    {clock_source_in, widget_spread_in, comp_enable_in, tx_clock_divider_in, comp_divider_in} =
      {r.src, r.ws, r.ce, r.div, r.cd};
    {reference_dac_code_in, compensation_dac_code_in, init_subconversions_in, subconversion_count_in} =
      {r.rf, r.cc, r.ini, r.n};
    start_in = 1'h1;
    @(posedge clk_in);
    #2 start_in = 1'h0;
    while (scan_done_out !== 1'h1 && cyc < 1000) begin
      @(posedge clk_in);
      #2;
      cyc++;
      start_in = poke && cyc == 40;
      if (tx_clock_out && !ptx) begin
        rises++;
        if (rises == 1) first = cyc;
        if (rises == 2) gap = cyc - first;
      end
      comps += comp_dac_switch_out;
      refs += ref_dac_switch_out;
      ptx = tx_clock_out;
    end
    check("done_seen", scan_done_out, 1'h1);
    if (fixed) check("done_time", cyc >= 32 + span && cyc <= 37 + span, 1'h1);
    check("comp_code", comp_code_out, r.ce ? r.cc : 8'h00);
    if (!flood) check("ref_pulses", refs, r.ini * r.div - 6);
    check("tx_rises", rises, r.ini + r.n);
    if (flood) check("raw_low", raw_count_out < r.n * r.div, 1'h1);
    else check("raw_count", raw_count_out, r.n * r.div);
    if (!fixed) check("spread_gap", gap != r.div, 1'h1);
    if (!r.ce) check("comp_pulses", comps, 0);
    else if (fixed && !r.err) check("comp_pulses", comps, (r.ini + r.n) * (r.div / r.cd));
    check("config_error", config_error_out, r.err);
    if (!autocal_enable_in) check("ref_code", ref_code_out, r.rf);
  endtask
  initial begin
    {resetn_in, start_in, widget_spread_in, comp_enable_in, autocal_enable_in, flood, clock_source_in} = 0;
    {tx_clock_divider_in, comp_divider_in, init_subconversions_in} = {8'h08, 8'h04, 8'h02};
    {reference_dac_code_in, compensation_dac_code_in, subconversion_count_in} = {8'h06, 8'h00, 16'h0004};
    repeat (5) @(posedge clk_in);
    #2 resetn_in = 1'h1;
    foreach (rows[i]) do_row(rows[i], 1'h0);
    do_row(rows[0], 1'h1);
    @(posedge clk_in);
    #2 check("busy_idle", busy_out, 1'h0);
    flood = 1'h1;
    do_row(rows[0], 1'h0);
    flood = 1'h0;
    // reset in the middle of the short phase
    @(posedge clk_in);
    #2 start_in = 1'h1;
    @(posedge clk_in);
    #2 start_in = 1'h0;
    repeat (20) @(posedge clk_in);
    #2 resetn_in = 1'h0;
    #1 check("reset_outs", {busy_out, cap1_to_ground_out, caps_shorted_out, tx_clock_out, raw_count_out}, 0);
    @(posedge clk_in);
    #2 resetn_in = 1'h1;
    autocal_enable_in = 1'h1;
    do_row(rows[0], 1'h0);
    @(posedge clk_in);
    #2 check("cal_step", ref_code_out, 8'h7F);
    complete_run();
  end
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
endmodule
